// File: hdl/als_pkg.sv
// constants for the aux link settings shadow bank
// assumes one clock domain; aux addresses are 20-bit, smbus offsets 8-bit
package als_pkg;
    // smbus byte offsets of the shadow registers
    localparam logic [7:0]  SMB_LINK_RATE    = 8'h02;
    localparam logic [7:0]  SMB_LANE_COUNT   = 8'h03;
    localparam logic [7:0]  SMB_LANE0_TRAIN  = 8'h04;
    localparam logic [7:0]  SMB_LANE3_TRAIN  = 8'h07;
    localparam logic [7:0]  SMB_SPREAD       = 8'h08;

    // aux addresses watched by the listener
    localparam logic [19:0] AUX_LINK_RATE    = 20'h00100;
    localparam logic [19:0] AUX_LANE_COUNT   = 20'h00101;
    localparam logic [19:0] AUX_LANE0_TRAIN  = 20'h00103;
    localparam logic [19:0] AUX_SPREAD       = 20'h00107;
    localparam logic [19:0] AUX_ADJUST_01    = 20'h00206;
    localparam logic [19:0] AUX_ADJUST_23    = 20'h00207;
    localparam logic [19:0] AUX_TEST_RATE    = 20'h00219;
    localparam logic [19:0] AUX_TEST_LANES   = 20'h00220;
    localparam logic [19:0] AUX_TEST_ACK     = 20'h00260;

    // reset values
    localparam logic [7:0]  RST_LINK_RATE    = 8'h14;
    localparam logic [7:0]  RST_LANE_COUNT   = 8'h04;
    localparam logic [7:0]  RST_LANE_TRAIN   = 8'h00;
    localparam logic [7:0]  RST_SPREAD       = 8'h00;

    // link rate codes
    localparam logic [7:0]  RATE_1G62        = 8'h06;
    localparam logic [7:0]  RATE_2G7         = 8'h0A;
    localparam logic [7:0]  RATE_5G4         = 8'h14;

    // lane count codes and fields
    localparam logic [4:0]  LANES_ONE        = 5'h01;
    localparam logic [4:0]  LANES_TWO        = 5'h02;
    localparam logic [4:0]  LANES_FOUR       = 5'h04;
    localparam int          LC_COUNT_MSB     = 4;
    localparam int          LC_ENH_BIT       = 7;
    localparam logic [7:0]  LC_V11_MASK      = 8'h9F;
    localparam logic [7:0]  LC_V10_MASK      = 8'h1F;

    // lane training fields
    localparam int          TR_DRIVE_LSB     = 0;
    localparam int          TR_DRIVE_MAX_BIT = 2;
    localparam int          TR_PRE_LSB       = 3;
    localparam int          TR_PRE_MAX_BIT   = 5;
    localparam logic [7:0]  TR_MASK          = 8'h3F;

    // down-spread fields
    localparam int          SP_AMP_BIT       = 4;
    localparam logic [7:0]  SP_MASK          = 8'h10;

    // sink test acknowledge codes (bits 1:0)
    localparam logic [1:0]  ACK_ENTER        = 2'h1;
    localparam logic [1:0]  ACK_DECLINE      = 2'h2;
endpackage

// File: hdl/als_lane_shadow.sv
// one lane training shadow byte with its sink-test override and lane enable
// assumes the parent supplies decoded, same-clock write strobes
`timescale 1ns/1ns
module als_lane_shadow #(
    parameter logic [2:0] LANE_IDX = 3'h0
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       aux_we_i,
    input  wire logic [7:0] aux_data_i,
    input  wire logic       smb_we_i,
    input  wire logic [7:0] smb_data_i,
    input  wire logic       test_mode_i,
    input  wire logic [3:0] adjust_i,
    input  wire logic [4:0] lane_count_i,
    output logic      [7:0] store_o,
    output logic      [7:0] train_o,
    output logic            en_o
);
    logic [7:0] store_ff;
    logic [7:0] nxt_store;
    logic [7:0] train_ff;
    logic [7:0] nxt_train;
    logic       en_ff;
    logic       nxt_en;
    logic       legal;

    always_comb begin
        nxt_store = store_ff;
        // listener capture wins over smbus
        if (aux_we_i) begin
            nxt_store = aux_data_i & als_pkg::TR_MASK;
        end else if (smb_we_i) begin
            nxt_store = smb_data_i & als_pkg::TR_MASK;
        end
        nxt_train = store_ff;
        if (test_mode_i) begin
            // adjust request: swing in 1:0, pre-emphasis in 3:2; max flags dropped
            nxt_train = 8'h00;
            nxt_train[als_pkg::TR_DRIVE_LSB +: 2] = adjust_i[1:0];
            nxt_train[als_pkg::TR_PRE_LSB +: 2]   = adjust_i[3:2];
        end
        legal = (lane_count_i == als_pkg::LANES_ONE) ||
                (lane_count_i == als_pkg::LANES_TWO) ||
                (lane_count_i == als_pkg::LANES_FOUR);
        // reserved lane counts switch every lane off
        nxt_en = legal && ({2'h0, LANE_IDX} < lane_count_i);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            store_ff <= als_pkg::RST_LANE_TRAIN;
            train_ff <= als_pkg::RST_LANE_TRAIN;
            en_ff    <= 1'b0;
        end else if (ce_i) begin
            store_ff <= nxt_store;
            train_ff <= nxt_train;
            en_ff    <= nxt_en;
        end
    end

    assign store_o = store_ff;
    assign train_o = train_ff;
    assign en_o    = en_ff;
endmodule

// File: hdl/als_shadow_top.sv
// aux link settings shadow bank: listener capture plus smbus byte access
// assumes an external aux parser and smbus engine on the same clock
`timescale 1ns/1ns
module als_shadow_top (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CE_I,
    input  wire logic        DPCD_V11_I,
    input  wire logic        AUX_MODE_I,
    input  wire logic        AUX_VALID_I,
    input  wire logic [19:0] AUX_ADDR_I,
    input  wire logic [7:0]  AUX_DATA_I,
    input  wire logic        SMB_WR_I,
    input  wire logic        SMB_RD_I,
    input  wire logic [7:0]  SMB_ADDR_I,
    input  wire logic [7:0]  SMB_WDATA_I,
    output logic      [7:0]  SMB_RDATA_O,
    output logic             SMB_RVALID_O,
    output logic      [7:0]  LINK_RATE_O,
    output logic             RATE_VALID_O,
    output logic      [4:0]  LANE_COUNT_O,
    output logic             ENH_FRAMING_O,
    output logic      [3:0]  LANE_EN_O,
    output logic      [31:0] LANE_TRAIN_O,
    output logic             SPREAD_AMPLITUDE_O,
    output logic             TEST_MODE_O
);
    logic        rst_meta_ff;
    logic        rst_sync_ff;

    logic [7:0]  rate_ff;
    logic [7:0]  nxt_rate;
    logic [7:0]  lanes_ff;
    logic [7:0]  nxt_lanes;
    logic [7:0]  spread_ff;
    logic [7:0]  nxt_spread;
    logic [7:0]  adj01_ff;
    logic [7:0]  nxt_adj01;
    logic [7:0]  adj23_ff;
    logic [7:0]  nxt_adj23;
    logic [7:0]  trate_ff;
    logic [7:0]  nxt_trate;
    logic [7:0]  tlanes_ff;
    logic [7:0]  nxt_tlanes;
    logic        tmode_ff;
    logic        nxt_tmode;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [7:0]  orate_ff;
    logic [7:0]  nxt_orate;
    logic        rvld_ff;
    logic        nxt_rvld;
    logic [4:0]  ocount_ff;
    logic [4:0]  nxt_ocount;
    logic        enh_ff;
    logic        nxt_enh;
    logic        amp_ff;
    logic        nxt_amp;

    logic        smb_we;
    logic [4:0]  eff_count;
    logic [3:0]  aux_lane_we;
    logic [3:0]  smb_lane_we;
    logic [15:0] adjust_all;
    logic [7:0]  lane_store [0:3];
    logic [7:0]  lanes_read;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // smbus writes are dropped while the listener owns the bank
    assign smb_we     = SMB_WR_I && !AUX_MODE_I;
    assign eff_count  = tmode_ff ? tlanes_ff[als_pkg::LC_COUNT_MSB:0]
                                 : lanes_ff[als_pkg::LC_COUNT_MSB:0];
    assign adjust_all = {adj23_ff, adj01_ff};
    // version 1.0 hides the framing bit
    assign lanes_read = lanes_ff & (DPCD_V11_I ? als_pkg::LC_V11_MASK
                                               : als_pkg::LC_V10_MASK);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign aux_lane_we[gi] = AUX_VALID_I &&
                (AUX_ADDR_I == als_pkg::AUX_LANE0_TRAIN + 20'(gi));
            assign smb_lane_we[gi] = smb_we &&
                (SMB_ADDR_I == als_pkg::SMB_LANE0_TRAIN + 8'(gi));
            als_lane_shadow #(
                .LANE_IDX     (3'(gi))
            ) u_lane (
                .clk_i        (CLK_I),
                .rst_n_i      (rst_sync_ff),
                .ce_i         (CE_I),
                .aux_we_i     (aux_lane_we[gi]),
                .aux_data_i   (AUX_DATA_I),
                .smb_we_i     (smb_lane_we[gi]),
                .smb_data_i   (SMB_WDATA_I),
                .test_mode_i  (tmode_ff),
                .adjust_i     (adjust_all[gi*4 +: 4]),
                .lane_count_i (eff_count),
                .store_o      (lane_store[gi]),
                .train_o      (LANE_TRAIN_O[gi*8 +: 8]),
                .en_o         (LANE_EN_O[gi])
            );
        end
    endgenerate

    always_comb begin
        nxt_rate   = rate_ff;
        nxt_lanes  = lanes_ff;
        nxt_spread = spread_ff;
        nxt_adj01  = adj01_ff;
        nxt_adj23  = adj23_ff;
        nxt_trate  = trate_ff;
        nxt_tlanes = tlanes_ff;
        nxt_tmode  = tmode_ff;
        // aux capture takes precedence over an smbus write in the same cycle
        if (AUX_VALID_I) begin
            if (AUX_ADDR_I == als_pkg::AUX_LINK_RATE) begin
                nxt_rate = AUX_DATA_I;
            end else if (AUX_ADDR_I == als_pkg::AUX_LANE_COUNT) begin
                nxt_lanes = AUX_DATA_I & als_pkg::LC_V11_MASK;
            end else if (AUX_ADDR_I == als_pkg::AUX_SPREAD) begin
                nxt_spread = AUX_DATA_I & als_pkg::SP_MASK;
            end else if (AUX_ADDR_I == als_pkg::AUX_ADJUST_01) begin
                nxt_adj01 = AUX_DATA_I;
            end else if (AUX_ADDR_I == als_pkg::AUX_ADJUST_23) begin
                nxt_adj23 = AUX_DATA_I;
            end else if (AUX_ADDR_I == als_pkg::AUX_TEST_RATE) begin
                nxt_trate = AUX_DATA_I;
            end else if (AUX_ADDR_I == als_pkg::AUX_TEST_LANES) begin
                nxt_tlanes = AUX_DATA_I;
            end else if (AUX_ADDR_I == als_pkg::AUX_TEST_ACK) begin
                // code 11 is not legal and leaves the mode unchanged
                if (AUX_DATA_I[1:0] == als_pkg::ACK_ENTER) begin
                    nxt_tmode = 1'b1;
                end else if (AUX_DATA_I[1:0] == als_pkg::ACK_DECLINE) begin
                    nxt_tmode = 1'b0;
                end
            end
        end else if (smb_we) begin
            if (SMB_ADDR_I == als_pkg::SMB_LINK_RATE) begin
                nxt_rate = SMB_WDATA_I;
            end else if (SMB_ADDR_I == als_pkg::SMB_LANE_COUNT) begin
                nxt_lanes = SMB_WDATA_I & als_pkg::LC_V11_MASK;
            end else if (SMB_ADDR_I == als_pkg::SMB_SPREAD) begin
                nxt_spread = SMB_WDATA_I & als_pkg::SP_MASK;
            end
        end

        // read data registered one cycle after the strobe; unmapped reads 00h
        nxt_rvalid = SMB_RD_I;
        nxt_rdata  = rdata_ff;
        if (SMB_RD_I) begin
            if (SMB_ADDR_I == als_pkg::SMB_LINK_RATE) begin
                nxt_rdata = rate_ff;
            end else if (SMB_ADDR_I == als_pkg::SMB_LANE_COUNT) begin
                nxt_rdata = lanes_read;
            end else if (SMB_ADDR_I >= als_pkg::SMB_LANE0_TRAIN &&
                         SMB_ADDR_I <= als_pkg::SMB_LANE3_TRAIN) begin
                nxt_rdata = lane_store[SMB_ADDR_I[1:0]];
            end else if (SMB_ADDR_I == als_pkg::SMB_SPREAD) begin
                nxt_rdata = spread_ff;
            end else begin
                nxt_rdata = 8'h00;
            end
        end

        nxt_orate  = tmode_ff ? trate_ff : rate_ff;
        // reserved rate codes pass through but are flagged
        nxt_rvld   = (nxt_orate == als_pkg::RATE_1G62) ||
                     (nxt_orate == als_pkg::RATE_2G7)  ||
                     (nxt_orate == als_pkg::RATE_5G4);
        nxt_ocount = eff_count;
        // framing only exists under v1.1 and follows the stored setting
        nxt_enh    = DPCD_V11_I && lanes_ff[als_pkg::LC_ENH_BIT];
        nxt_amp    = spread_ff[als_pkg::SP_AMP_BIT];
    end

    always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rate_ff   <= als_pkg::RST_LINK_RATE;
            lanes_ff  <= als_pkg::RST_LANE_COUNT;
            spread_ff <= als_pkg::RST_SPREAD;
            adj01_ff  <= 8'h00;
            adj23_ff  <= 8'h00;
            trate_ff  <= 8'h00;
            tlanes_ff <= 8'h00;
            tmode_ff  <= 1'b0;
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
            orate_ff  <= als_pkg::RST_LINK_RATE;
            rvld_ff   <= 1'b1;
            ocount_ff <= als_pkg::RST_LANE_COUNT[4:0];
            enh_ff    <= 1'b0;
            amp_ff    <= 1'b0;
        end else if (CE_I) begin
            rate_ff   <= nxt_rate;
            lanes_ff  <= nxt_lanes;
            spread_ff <= nxt_spread;
            adj01_ff  <= nxt_adj01;
            adj23_ff  <= nxt_adj23;
            trate_ff  <= nxt_trate;
            tlanes_ff <= nxt_tlanes;
            tmode_ff  <= nxt_tmode;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            orate_ff  <= nxt_orate;
            rvld_ff   <= nxt_rvld;
            ocount_ff <= nxt_ocount;
            enh_ff    <= nxt_enh;
            amp_ff    <= nxt_amp;
        end
    end

    assign SMB_RDATA_O        = rdata_ff;
    assign SMB_RVALID_O       = rvalid_ff;
    assign LINK_RATE_O        = orate_ff;
    assign RATE_VALID_O       = rvld_ff;
    assign LANE_COUNT_O       = ocount_ff;
    assign ENH_FRAMING_O      = enh_ff;
    assign SPREAD_AMPLITUDE_O = amp_ff;
    assign TEST_MODE_O        = tmode_ff;
endmodule

// File: tb/als_aux_src.sv
// aux source model: presents captured aux bytes as the parser would
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ns
module als_aux_src (
    input  wire logic        clk_i,
    output logic             valid_o = 1'b0,
    output logic      [19:0] addr_o = 20'h00000,
    output logic      [7:0]  data_o = 8'h00
);
    // gap cycles model a slow source
    task automatic send(input logic [19:0] a, input logic [7:0] d, input int gap);
        @(posedge clk_i);
        valid_o <= 1'b1;
        addr_o  <= a;
        data_o  <= d;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // released bus shows no stale copy
        addr_o  <= ~a;
        data_o  <= ~d;
        repeat (gap) @(posedge clk_i);
    endtask
    // caller passes rate and lanes already clipped to sink capability
    task automatic train(input logic [7:0] rate, input logic [4:0] lanes, input logic cap);
        send(20'h00100, rate, 0);
        send(20'h00101, {cap, 2'h0, lanes}, 1);
        for (int i = 0; i < 4; i++)
            send(20'h00103 + 20'(i), 8'h04, 0);
        send(20'h00107, 8'h00, 2);
    endtask
endmodule

// File: tb/als_shadow_chk.sv
// port assertions for the shadow bank
// assumes a bind onto als_shadow_top and one clock domain
`timescale 1ns/1ns
module als_shadow_chk (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        CE_I,
    input wire logic        DPCD_V11_I,
    input wire logic        AUX_VALID_I,
    input wire logic [19:0] AUX_ADDR_I,
    input wire logic [7:0]  AUX_DATA_I,
    input wire logic        SMB_RD_I,
    input wire logic [7:0]  SMB_ADDR_I,
    input wire logic [7:0]  SMB_RDATA_O,
    input wire logic        SMB_RVALID_O,
    input wire logic [7:0]  LINK_RATE_O,
    input wire logic        RATE_VALID_O,
    input wire logic [4:0]  LANE_COUNT_O,
    input wire logic        ENH_FRAMING_O,
    input wire logic [3:0]  LANE_EN_O,
    input wire logic [31:0] LANE_TRAIN_O,
    input wire logic        TEST_MODE_O
);
    logic [2:0] up_ff;
    logic [2:0] nxt_up;
    logic       live;
    // lane enables lag the reset synchroniser by a few edges
    always_comb nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
    always_ff @(posedge CLK_I or negedge RST_N_I)
        if (!RST_N_I)
            up_ff <= 3'h0;
        else
            up_ff <= nxt_up;
    assign live = (up_ff == 3'h7);
    function automatic logic [3:0] lmap(input logic [4:0] c);
        return (c == 5'h01) ? 4'h1 : (c == 5'h02) ? 4'h3 : (c == 5'h04) ? 4'hF : 4'h0;
    endfunction
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    rvalid_pulse_a: assert property (CE_I |=> SMB_RVALID_O == $past(SMB_RD_I))
        else $error("read valid does not follow read request");
    rate_valid_a: assert property (
        RATE_VALID_O == (LINK_RATE_O inside {8'h06, 8'h0A, 8'h14}))
        else $error("rate valid flag disagrees with rate code");
    lane_map_a: assert property (
        live && CE_I |=> LANE_EN_O == lmap(LANE_COUNT_O))
        else $error("lane enables disagree with lane count");
    enh_ver_a: assert property (
        ENH_FRAMING_O && $stable(DPCD_V11_I) |-> DPCD_V11_I)
        else $error("enhanced framing under old version");
    rdata_hold_a: assert property (!SMB_RD_I |=> $stable(SMB_RDATA_O))
        else $error("read data changed without read");
    lc_read_a: assert property (
        SMB_RVALID_O && $past(SMB_ADDR_I) == 8'h03 |->
            SMB_RDATA_O[6:5] == 2'h0 && (!SMB_RDATA_O[7] || $past(DPCD_V11_I)))
        else $error("lane count reserved bits read nonzero");
    train_bits_a: assert property (
        (LANE_TRAIN_O & 32'hC0C0C0C0) == 32'h0)
        else $error("training byte bits 7:6 set");
    aux_rate_a: assert property (
        live && CE_I && AUX_VALID_I && AUX_ADDR_I == 20'h00100 && !TEST_MODE_O
            |=> ##1 LINK_RATE_O == $past(AUX_DATA_I, 2))
        else $error("captured rate not shown");
endmodule
bind als_shadow_top als_shadow_chk u_chk (.*);

// File: tb/als_shadow_tb_top.sv
// self-checking bench for the shadow bank, aux source model and smbus tasks
// assumes the checker binds itself; one 25 MHz clock
`timescale 1ns/1ns
module als_shadow_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, v11 = 1'b1, aux_mode = 1'b0;
    logic        smb_wr = 1'b0, smb_rd = 1'b0;
    logic [7:0]  smb_addr = 8'h00, smb_wdata = 8'h00, rdata, link_rate, got, rt;
    logic        rvalid, rate_valid, enh, spread, test_mode, aux_valid;
    logic [4:0]  lane_count, lc;
    logic [3:0]  lane_en;
    logic [31:0] lane_train, tr_exp;
    logic [19:0] aux_addr;
    logic [7:0]  aux_data;
    logic [15:0] lfsr = 16'h0FD4;
    logic [7:0]  shadow [2:8];
    int          mismatches = 0;
    int          tests_run = 0;
    always #20 clk = ~clk;
    als_aux_src u_src (.clk_i(clk), .valid_o(aux_valid), .addr_o(aux_addr), .data_o(aux_data));
    als_shadow_top u_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .DPCD_V11_I(v11), .AUX_MODE_I(aux_mode),
        .AUX_VALID_I(aux_valid), .AUX_ADDR_I(aux_addr), .AUX_DATA_I(aux_data),
        .SMB_WR_I(smb_wr), .SMB_RD_I(smb_rd), .SMB_ADDR_I(smb_addr), .SMB_WDATA_I(smb_wdata),
        .SMB_RDATA_O(rdata), .SMB_RVALID_O(rvalid), .LINK_RATE_O(link_rate),
        .RATE_VALID_O(rate_valid), .LANE_COUNT_O(lane_count), .ENH_FRAMING_O(enh),
        .LANE_EN_O(lane_en), .LANE_TRAIN_O(lane_train), .SPREAD_AMPLITUDE_O(spread),
        .TEST_MODE_O(test_mode));
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // v high gives the stored mask; low gives the old-version read mask
    function automatic logic [7:0] msk(input logic [7:0] a, input logic [7:0] d, input logic v);
        if (a == 8'h02)
            return d;
        if (a == 8'h03)
            return d & (v ? als_pkg::LC_V11_MASK : als_pkg::LC_V10_MASK);
        if (a == 8'h08)
            return d & als_pkg::SP_MASK;
        return (a >= 8'h04 && a <= 8'h07) ? d & als_pkg::TR_MASK : 8'h00;
    endfunction
    function automatic logic [3:0] lmap(input logic [4:0] c);
        return (c == 5'h01) ? 4'h1 : (c == 5'h02) ? 4'h3 : (c == 5'h04) ? 4'hF : 4'h0;
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic smb_w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        smb_wr    <= 1'b1;
        smb_addr  <= a;
        smb_wdata <= d;
        @(posedge clk);
        smb_wr    <= 1'b0;
        smb_wdata <= ~d;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        smb_rd   <= 1'b1;
        smb_addr <= a;
        @(posedge clk);
        smb_rd   <= 1'b0;
        #1;
        chk("read valid", 1, rvalid);
        got = (a >= 8'h02 && a <= 8'h08) ? msk(a, shadow[a], v11) : 8'h00;
        chk("smbus read", got, rdata);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        shadow = '{8'h14, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int a = 1; a <= 9; a++)
            rd_chk(8'(a));
        chk("reset lanes", 4'hF, lane_en);
        for (int p = 0; p < 6; p++) begin
            @(posedge clk);
            v11 <= p[0];
            for (int a = 2; a <= 8; a++) begin
                lfsr = step(lfsr);
                smb_w(8'(a), lfsr[7:0]);
                shadow[a] = msk(8'(a), lfsr[7:0], 1'b1);
            end
            for (int a = 2; a <= 8; a++)
                rd_chk(8'(a));
            chk("spread out", shadow[8][4], spread);
            chk("framing", shadow[3][7] & v11, enh);
            chk("lane enable", lmap(shadow[3][4:0]), lane_en);
            chk("rate valid", shadow[2] inside {8'h06, 8'h0A, 8'h14}, rate_valid);
            tr_exp = {shadow[7], shadow[6], shadow[5], shadow[4]};
            chk("lane train", tr_exp, lane_train);
        end
        @(posedge clk);
        aux_mode <= 1'b1;
        smb_w(8'h02, ~shadow[2]);
        rd_chk(8'h02);
        @(posedge clk);
        aux_mode <= 1'b0;
        ce       <= 1'b0;
        smb_w(8'h02, ~shadow[2]);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(8'h02);
        // three legal lane codes and one reserved one
        for (int i = 0; i < 4; i++) begin
            lc = (i == 3) ? 5'h03 : 5'(1 << i);
            rt = (i == 0) ? 8'h06 : (i == 1) ? 8'h0A : 8'h14;
            u_src.train(rt, lc, i[0]);
            #1;
            chk("link rate", rt, link_rate);
            chk("lane count", lc, lane_count);
            chk("lane enable", lmap(lc), lane_en);
            chk("framing", i[0] & v11, enh);
            shadow = '{rt, {i[0], 2'h0, lc}, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00};
            for (int a = 2; a <= 8; a++)
                rd_chk(8'(a));
            tr_exp = {shadow[7], shadow[6], shadow[5], shadow[4]};
            chk("lane train", tr_exp, lane_train);
        end
        lfsr = step(lfsr);
        u_src.send(20'h00206, lfsr[7:0], 0);
        u_src.send(20'h00207, lfsr[15:8], 0);
        u_src.send(20'h00219, 8'h0A, 0);
        u_src.send(20'h00220, 8'h02, 0);
        u_src.send(20'h00260, 8'h01, 2);
        #1;
        chk("test mode", 1, test_mode);
        chk("test lanes", 5'h02, lane_count);
        chk("test lane en", 4'h3, lane_en);
        chk("test rate", 8'h0A, link_rate);
        chk("lane0 test", {3'h0, lfsr[3:2], 1'b0, lfsr[1:0]}, lane_train[7:0]);
        chk("lane1 test", {3'h0, lfsr[7:6], 1'b0, lfsr[5:4]}, lane_train[15:8]);
        chk("lane2 test", {3'h0, lfsr[11:10], 1'b0, lfsr[9:8]}, lane_train[23:16]);
        chk("lane3 test", {3'h0, lfsr[15:14], 1'b0, lfsr[13:12]}, lane_train[31:24]);
        // code 11 is no legal acknowledge and must leave the mode alone
        u_src.send(20'h00260, 8'h03, 2);
        #1;
        chk("bad ack", 1, test_mode);
        u_src.send(20'h00260, 8'h02, 2);
        #1;
        chk("test exit", 0, test_mode);
        chk("lanes back", shadow[3][4:0], lane_count);
        chk("train back", tr_exp, lane_train);
        // mid-run reset must bring every shadow back to its default
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        shadow = '{8'h14, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int a = 2; a <= 8; a++)
            rd_chk(8'(a));
        chk("reset test mode", 0, test_mode);
        chk("reset rate", 8'h14, link_rate);
        chk("reset lanes", 4'hF, lane_en);
        results();
    end
endmodule
